// ---- logic/timer_map.vh ----
// Function
// - Run clear holds counter at zero
// - Clock-select field picks prescaled count clock
// - Mode field: 00 interval, 10 PWM
// - Output-level bit sets default output level
// - Output-enable bit gates the timer pin
// - Counting starts within one count clock
// - Interval match clears, toggles output, interrupts
// - Interrupt recurs every N+1 count clocks
// - Run clear forces interrupt and output inactive
// - PWM period match clears, interrupts, activates
// - PWM duty match deactivates, no clear, no interrupt
// - PWM period N+1, active width M+1
// - PWM start masks one count clock
// - Duty transfer needs three count clocks
// - Control register bit/byte writable, resets zero
// - New duty latched, moved on old match
// - Write at match waits for next match
`ifndef TIMER_MAP_VH
`define TIMER_MAP_VH
`define ADDR_MODE_CTRL   16'hff70
`define ADDR_PERIOD_CMP  16'hff71
`define ADDR_DUTY_CMP    16'hff72
`define MODE_CTRL_RESET  8'h00
`define CMP_RESET        8'h00
`define BIT_RUN          7
`define CKS_MSB          6
`define CKS_LSB          4
`define MODE_MSB         3
`define MODE_LSB         2
`define BIT_LEVEL        1
`define BIT_OUT_EN       0
`define MODE_INTERVAL    2'b00
`define MODE_PWM         2'b10
`define CKS_DIV1         3'b000
`define CKS_DIV4         3'b001
`define CKS_DIV16        3'b010
`define CKS_DIV64        3'b011
`define CKS_DIV4096      3'b100
`define CKS_LOW_SPEED    3'b101
`define DIV_MASK4        12'h003
`define DIV_MASK16       12'h00f
`define DIV_MASK64       12'h03f
`define DIV_MASK4096     12'hfff
`define LS_DIV_LAST      7'h7f
`define DUTY_XFER_TICKS  2'h3
`endif

// ---- logic/count_tick_gen.v ----
`timescale 1ns/1ps
`include "timer_map.vh"
module count_tick_gen
#(
  parameter DIV_W    = 12,
  parameter LS_DIV_W = 7
)
(
  input  wire       clk_sys_i,
  input  wire       rstn_i,
  input  wire [2:0] clock_select_i,
  input  wire       low_speed_internal_clock_i,
  output wire       tick_o
);

  reg  [DIV_W-1:0]    div_q;
  reg  [LS_DIV_W-1:0] ls_cnt_q;
  reg                 ls_meta_q;
  reg                 ls_sync_q;
  reg                 ls_prev_q;
  reg                 tick_q;
  reg                 tick_d;
  wire                ls_edge;

  assign ls_edge = ls_sync_q & ~ls_prev_q;
  assign tick_o  = tick_q;

  // Free-running chain on the peripheral clock
  always @(posedge clk_sys_i)
  begin
    if (!rstn_i)
    begin
      div_q     <= {DIV_W{1'b0}};
      ls_cnt_q  <= {LS_DIV_W{1'b0}};
      ls_meta_q <= 1'b0;
      ls_sync_q <= 1'b0;
      ls_prev_q <= 1'b0;
      tick_q    <= 1'b0;
    end
    else
    begin
      div_q     <= div_q + {{(DIV_W-1){1'b0}}, 1'b1};
      ls_meta_q <= low_speed_internal_clock_i;
      ls_sync_q <= ls_meta_q;
      ls_prev_q <= ls_sync_q;
      if (ls_edge)
        ls_cnt_q <= ls_cnt_q + {{(LS_DIV_W-1){1'b0}}, 1'b1};
      tick_q    <= tick_d;
    end
  end

  always @*
  begin
    case (clock_select_i)
      `CKS_DIV1:      tick_d = 1'b1;
      `CKS_DIV4:      tick_d = (div_q & `DIV_MASK4) == `DIV_MASK4;
      `CKS_DIV16:     tick_d = (div_q & `DIV_MASK16) == `DIV_MASK16;
      `CKS_DIV64:     tick_d = (div_q & `DIV_MASK64) == `DIV_MASK64;
      `CKS_DIV4096:   tick_d = (div_q & `DIV_MASK4096) == `DIV_MASK4096;
      `CKS_LOW_SPEED: tick_d = ls_edge & (ls_cnt_q == `LS_DIV_LAST);
      default:        tick_d = 1'b0;
    endcase
  end

endmodule // count_tick_gen

// ---- logic/timer_h_interval_pwm.v ----
`timescale 1ns/1ps
`include "timer_map.vh"
module timer_h_interval_pwm
#(
  parameter CNT_W = 8
)
(
  input  wire        clk_sys_i,
  input  wire        rstn_i,
  input  wire [15:0] cpu_addr_i,
  input  wire        cpu_wr_i,
  input  wire        cpu_bit_wr_i,
  input  wire [2:0]  cpu_bit_sel_i,
  input  wire        cpu_bit_val_i,
  input  wire [7:0]  cpu_wdata_i,
  input  wire        cpu_rd_i,
  output wire [7:0]  cpu_rdata_o,
  input  wire        low_speed_internal_clock_i,
  output wire        timer_output_pin_o,
  output wire        timer_output_pin_oe_o,
  output wire        timer_match_irq_o
);

  localparam [2:0] PH_MASK   = 3'b001;
  localparam [2:0] PH_PERIOD = 3'b010;
  localparam [2:0] PH_DUTY   = 3'b100;

  reg  [7:0]       timer_mode_control_q;
  reg  [7:0]       timer_mode_control_d;
  reg  [7:0]       period_compare_q;
  reg  [7:0]       duty_latch_q;
  reg  [7:0]       duty_compare_q;
  reg              duty_pending_q;
  reg  [1:0]       duty_age_q;
  reg  [CNT_W-1:0] count_q;
  reg  [CNT_W-1:0] count_d;
  reg  [2:0]       phase_q;
  reg  [2:0]       phase_d;
  reg              active_q;
  reg              active_d;
  reg              irq_q;
  reg              irq_d;
  reg              xfer_d;
  reg  [7:0]       rdata_q;
  reg  [7:0]       rdata_d;
  reg  [7:0]       duty_latch_d;
  reg  [7:0]       duty_compare_d;
  reg              duty_pending_d;
  reg  [1:0]       duty_age_d;

  wire             tick;
  wire             run_enable;
  wire [2:0]       clock_select;
  wire [1:0]       mode_sel;
  wire             pwm_mode;
  wire             output_default_level;
  wire             output_pin_enable;
  wire             hit_mode;
  wire             hit_period;
  wire             hit_duty;
  wire             duty_write;
  wire             period_match;
  wire             duty_match;
  wire             duty_ready;
  wire             ctl_write;
  wire             ctl_bit_write;
  wire             period_write;

  assign run_enable           = timer_mode_control_q[`BIT_RUN];
  assign clock_select         = timer_mode_control_q[`CKS_MSB:`CKS_LSB];
  assign mode_sel             = timer_mode_control_q[`MODE_MSB:`MODE_LSB];
  assign pwm_mode             = (mode_sel == `MODE_PWM);
  assign output_default_level = timer_mode_control_q[`BIT_LEVEL];
  assign output_pin_enable    = timer_mode_control_q[`BIT_OUT_EN];

  assign hit_mode   = (cpu_addr_i == `ADDR_MODE_CTRL);
  assign hit_period = (cpu_addr_i == `ADDR_PERIOD_CMP);
  assign hit_duty   = (cpu_addr_i == `ADDR_DUTY_CMP);
  assign duty_write = cpu_wr_i & hit_duty;
  assign ctl_write     = cpu_wr_i & hit_mode;
  assign ctl_bit_write = cpu_bit_wr_i & hit_mode;
  assign period_write  = cpu_wr_i & hit_period;

  assign period_match = (count_q == period_compare_q[CNT_W-1:0]);
  assign duty_match   = (count_q == duty_compare_q[CNT_W-1:0]);
  assign duty_ready   = duty_pending_q
                        & (duty_age_q == `DUTY_XFER_TICKS);

  // Output: inactive level is the default level, active is its inverse
  assign timer_output_pin_o    = output_default_level ^ active_q;
  assign timer_output_pin_oe_o = output_pin_enable;
  assign timer_match_irq_o     = irq_q;
  assign cpu_rdata_o           = rdata_q;

  count_tick_gen
  #(
    .DIV_W    (12),
    .LS_DIV_W (7)
  )
  u_tick
  (
    .clk_sys_i                  (clk_sys_i),
    .rstn_i                     (rstn_i),
    .clock_select_i             (clock_select),
    .low_speed_internal_clock_i (low_speed_internal_clock_i),
    .tick_o                     (tick)
  );

  // Control register: byte write or single-bit write
  always @*
  begin
    timer_mode_control_d = timer_mode_control_q;
    if (ctl_write)
      timer_mode_control_d = cpu_wdata_i;
    else if (ctl_bit_write)
      timer_mode_control_d[cpu_bit_sel_i] = cpu_bit_val_i;
  end

  // Counter, phase and output sequencing
  always @*
  begin
    count_d  = count_q;
    phase_d  = phase_q;
    active_d = active_q;
    irq_d    = 1'b0;
    xfer_d   = 1'b0;
    if (!run_enable)
    begin
      count_d  = {CNT_W{1'b0}};
      phase_d  = PH_MASK;
      active_d = 1'b0;
    end
    else if (tick)
    begin
      if (!pwm_mode)
      begin
        phase_d = PH_PERIOD;
        if (period_match)
        begin
          count_d  = {CNT_W{1'b0}};
          active_d = ~active_q;
          irq_d    = 1'b1;
        end
        else
          count_d = count_q + {{(CNT_W-1){1'b0}}, 1'b1};
      end
      else
      begin
        case (phase_q)
          PH_MASK:
          begin
            phase_d = PH_PERIOD;
          end
          PH_PERIOD:
          begin
            if (period_match)
            begin
              count_d  = {CNT_W{1'b0}};
              active_d = 1'b1;
              irq_d    = 1'b1;
              phase_d  = PH_DUTY;
            end
            else
              count_d = count_q + {{(CNT_W-1){1'b0}}, 1'b1};
          end
          PH_DUTY:
          begin
            count_d = count_q + {{(CNT_W-1){1'b0}}, 1'b1};
            if (duty_match)
            begin
              active_d = 1'b0;
              phase_d  = PH_PERIOD;
              xfer_d   = duty_ready & ~duty_write;
            end
          end
          default:
          begin
            phase_d = PH_MASK;
          end
        endcase
      end
    end
  end

  // Read data: mapped registers, zero elsewhere
  always @*
  begin
    case (cpu_addr_i)
      `ADDR_MODE_CTRL:
        rdata_d = timer_mode_control_q;
      `ADDR_PERIOD_CMP:
        rdata_d = period_compare_q;
      `ADDR_DUTY_CMP:
        rdata_d = duty_latch_q;
      default:
        rdata_d = 8'h00;
    endcase
  end

  // Control register
  always @(posedge clk_sys_i)
  begin
    if (!rstn_i)
      timer_mode_control_q <= `MODE_CTRL_RESET;
    else
      timer_mode_control_q <= timer_mode_control_d;
  end

  always @(posedge clk_sys_i)
  begin
    if (!rstn_i)
    begin
      count_q  <= {CNT_W{1'b0}};
      phase_q  <= PH_MASK;
      active_q <= 1'b0;
      irq_q    <= 1'b0;
    end
    else
    begin
      count_q  <= count_d;
      phase_q  <= phase_d;
      active_q <= active_d;
      irq_q    <= irq_d;
    end
  end

  // Read data holds until the next read
  always @(posedge clk_sys_i)
  begin
    if (!rstn_i)
      rdata_q <= 8'h00;
    else if (cpu_rd_i)
      rdata_q <= rdata_d;
  end

  // Period compare: software keeps it fixed while counting
  always @(posedge clk_sys_i)
  begin
    if (!rstn_i)
      period_compare_q <= `CMP_RESET;
    else if (period_write)
      period_compare_q <= cpu_wdata_i;
  end

  // Duty write: direct while stopped, latched while running
  always @*
  begin
    duty_latch_d   = duty_latch_q;
    duty_compare_d = duty_compare_q;
    duty_pending_d = duty_pending_q;
    duty_age_d     = duty_age_q;
    if (duty_write)
    begin
      duty_latch_d = cpu_wdata_i;
      duty_age_d   = 2'h0;
      if (!run_enable)
      begin
        duty_compare_d = cpu_wdata_i;
        duty_pending_d = 1'b0;
      end
      else
        duty_pending_d = 1'b1;
    end
    else
    begin
      if (run_enable && tick && duty_age_q != `DUTY_XFER_TICKS)
        duty_age_d = duty_age_q + 2'h1;
      if (xfer_d)
      begin
        duty_compare_d = duty_latch_q;
        duty_pending_d = 1'b0;
      end
    end
  end

  always @(posedge clk_sys_i)
  begin
    if (!rstn_i)
      duty_latch_q <= `CMP_RESET;
    else
      duty_latch_q <= duty_latch_d;
  end

  always @(posedge clk_sys_i)
  begin
    if (!rstn_i)
      duty_compare_q <= `CMP_RESET;
    else
      duty_compare_q <= duty_compare_d;
  end

  always @(posedge clk_sys_i)
  begin
    if (!rstn_i)
    begin
      duty_pending_q <= 1'b0;
      duty_age_q     <= 2'h0;
    end
    else
    begin
      duty_pending_q <= duty_pending_d;
      duty_age_q     <= duty_age_d;
    end
  end

endmodule // timer_h_interval_pwm

// ---- sim/timer_h_interval_pwm_chk.sv ----
`timescale 1ns/1ps
module timer_h_interval_pwm_chk
(
  input wire        clk_sys_i,
  input wire        rstn_i,
  input wire [15:0] cpu_addr_i,
  input wire        cpu_wr_i,
  input wire        cpu_bit_wr_i,
  input wire [2:0]  cpu_bit_sel_i,
  input wire        cpu_bit_val_i,
  input wire [7:0]  cpu_wdata_i,
  input wire        cpu_rd_i,
  input wire [7:0]  cpu_rdata_o,
  input wire        low_speed_internal_clock_i,
  input wire        timer_output_pin_o,
  input wire        timer_output_pin_oe_o,
  input wire        timer_match_irq_o
);
  reg  [7:0] ctl_q;
  wire       sel = cpu_addr_i == 16'hff70;
  wire       pwm = ctl_q[7] && ctl_q[3:2] == 2'b10;
  wire       stop_wr = sel && (cpu_wr_i ? !cpu_wdata_i[7] :
                       cpu_bit_wr_i && cpu_bit_sel_i == 3'h7 && !cpu_bit_val_i);
  // Shadow of the mode/control register
  always @(posedge clk_sys_i)
  begin
    if (!rstn_i)
      ctl_q <= 8'h00;
    else if (cpu_wr_i && sel)
      ctl_q <= cpu_wdata_i;
    else if (cpu_bit_wr_i && sel)
      ctl_q[cpu_bit_sel_i] <= cpu_bit_val_i;
  end
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (!rstn_i);
  oe_follow_a: assert property (timer_output_pin_oe_o == ctl_q[0])
    else $error("pin enable differs from control bit");
  ctl_read_a: assert property (cpu_rd_i && sel && !cpu_wr_i
    && !cpu_bit_wr_i |=> cpu_rdata_o == ctl_q) else $error("bad ctl read");
  hole_read_a: assert property (cpu_rd_i && cpu_addr_i[15:4] != 12'hff7
    |=> cpu_rdata_o == 8'h00) else $error("unmapped read not zero");
  rdata_hold_a: assert property (!cpu_rd_i |=> $stable(cpu_rdata_o))
    else $error("read data moved without read");
  stop_level_a: assert property (stop_wr |=> ##1
    (timer_output_pin_o == ctl_q[1] && !timer_match_irq_o))
    else $error("stop did not restore default level");
  idle_quiet_a: assert property (!ctl_q[7] |=> !timer_match_irq_o)
    else $error("interrupt while stopped");
  match_pin_a: assert property (timer_match_irq_o |->
    $changed(timer_output_pin_o)) else $error("match without pin change");
  duty_noirq_a: assert property (pwm && $changed(timer_output_pin_o) &&
    timer_output_pin_o == ctl_q[1] |-> !timer_match_irq_o)
    else $error("interrupt on duty match");
  irq_pulse_a: assert property (timer_match_irq_o && ctl_q[6:4] != 3'h0
    |=> !timer_match_irq_o) else $error("interrupt wider than one clock");
  cover property (timer_match_irq_o);
  cover property (cpu_rd_i && sel);
  cover property (pwm && $fell(timer_output_pin_o));
endmodule // timer_h_interval_pwm_chk
bind timer_h_interval_pwm timer_h_interval_pwm_chk timer_h_interval_pwm_chk_i (
  .clk_sys_i(clk_sys_i), .rstn_i(rstn_i), .cpu_addr_i(cpu_addr_i),
  .cpu_wr_i(cpu_wr_i), .cpu_bit_wr_i(cpu_bit_wr_i),
  .cpu_bit_sel_i(cpu_bit_sel_i), .cpu_bit_val_i(cpu_bit_val_i),
  .cpu_wdata_i(cpu_wdata_i), .cpu_rd_i(cpu_rd_i), .cpu_rdata_o(cpu_rdata_o),
  .low_speed_internal_clock_i(low_speed_internal_clock_i),
  .timer_output_pin_o(timer_output_pin_o),
  .timer_output_pin_oe_o(timer_output_pin_oe_o),
  .timer_match_irq_o(timer_match_irq_o));

// ---- sim/low_speed_osc.sv ----
`timescale 1ns/1ps
module low_speed_osc
#(
  parameter HALF_NS = 40
)
(
  output reg clk_o
);
  // Free-running, offset from the system clock edges
  initial
  begin
    clk_o = 1'b0;
    #3;
    forever #HALF_NS clk_o = ~clk_o;
  end
endmodule // low_speed_osc

// ---- sim/test_timer_h_interval_pwm.sv ----
`timescale 1ns/1ps
module test_timer_h_interval_pwm;
  reg         clk_sys_i = 1'b0;
  reg         rstn_i = 1'b0;
  reg  [15:0] addr = 16'h0000;
  reg         wr = 1'b0;
  reg         bwr = 1'b0;
  reg  [2:0]  bsel = 3'h0;
  reg         bval = 1'b0;
  reg  [7:0]  wdata = 8'h00;
  reg         rd = 1'b0;
  wire [7:0]  rdata;
  wire        ls_clk;
  wire        pin;
  wire        oe;
  wire        irq;
  integer     num_errors = 0;
  integer     tests_run = 0;
  integer     n;
  integer     w;
  integer     c;
  integer     dv [0:5];
  always #5 clk_sys_i = ~clk_sys_i;
  low_speed_osc low_speed_osc_i (.clk_o(ls_clk));
  timer_h_interval_pwm timer_h_interval_pwm_i (
    .clk_sys_i(clk_sys_i), .rstn_i(rstn_i), .cpu_addr_i(addr),
    .cpu_wr_i(wr), .cpu_bit_wr_i(bwr), .cpu_bit_sel_i(bsel),
    .cpu_bit_val_i(bval), .cpu_wdata_i(wdata), .cpu_rd_i(rd),
    .cpu_rdata_o(rdata), .low_speed_internal_clock_i(ls_clk),
    .timer_output_pin_o(pin), .timer_output_pin_oe_o(oe),
    .timer_match_irq_o(irq));
  task step;
  begin
    @(posedge clk_sys_i);
    #1;
  end
  endtask
  task chk(input string nm, input [15:0] e, input [15:0] g);
  begin
    tests_run = tests_run + 1;
    if (g !== e)
    begin
      num_errors = num_errors + 1;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  end
  endtask
  task wrb(input [15:0] a, input [7:0] d);
  begin
    addr = a;
    wdata = d;
    wr = 1'b1;
    step;
    wr = 1'b0;
    step;
  end
  endtask
  task wrbit(input [2:0] s, input v);
  begin
    addr = 16'hff70;
    bsel = s;
    bval = v;
    bwr = 1'b1;
    step;
    bwr = 1'b0;
    step;
  end
  endtask
  task rdc(input string nm, input [15:0] a, input [7:0] e);
  begin
    addr = a;
    rd = 1'b1;
    step;
    rd = 1'b0;
    chk(nm, e, rdata);
    step;
  end
  endtask
  // Cycles until the next interrupt, or lim if none
  task wait_irq(input integer lim);
  begin
    n = 0;
    do begin step; n = n + 1; end while (irq !== 1'b1 && n < lim);
  end
  endtask
  task test_done;
  begin
    $display("checks %0d errors %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  end
  endtask
  initial
  begin
    #500000;
    num_errors = num_errors + 1;
    test_done;
  end
  initial
  begin
    dv = '{1, 4, 16, 64, 4096, 1024};
    step;
    step;
    rstn_i = 1'b1;
    rdc("ctl", 16'hff70, 8'h00);
    rdc("hole", 16'hff73, 8'h00);
    chk("oe", 0, oe);
    wrbit(3'h1, 1'b1);
    rdc("ctl", 16'hff70, 8'h02);
    chk("level", 1, pin);
    wrbit(3'h0, 1'b1);
    chk("oe", 1, oe);
    wrb(16'hff70, 8'h01);
    chk("level", 0, pin);
    wrb(16'hff71, 8'h02);
    for (c = 0; c < 6; c = c + 1)
    begin
      wrb(16'hff70, {1'b1, c[2:0], 4'h1});
      wait_irq(40000);
      chk("toggle", 1, pin);
      wait_irq(40000);
      chk("interval", 3 * dv[c], n);
      wrbit(3'h7, 1'b0);
      chk("stopped", 0, irq);
    end
    wrb(16'hff70, 8'he1);
    wait_irq(500);
    chk("no tick", 500, n);
    wrbit(3'h7, 1'b0);
    wait_irq(50);
    chk("held", 50, n);
    wrb(16'hff71, 8'h04);
    wrb(16'hff72, 8'h01);
    wrb(16'hff70, 8'h09);
    wrbit(3'h7, 1'b1);
    chk("masked", 0, pin);
    wait_irq(100);
    chk("first period", 5, n);
    chk("active", 1, pin);
    w = 0;
    do begin step; w = w + 1; end while (pin === 1'b1 && w < 300);
    chk("duty", 2, w);
    wait_irq(100);
    chk("period", 5, n + w);
    wrb(16'hff72, 8'h02);
    rdc("duty", 16'hff72, 8'h02);
    wait_irq(100);
    wait_irq(100);
    w = 0;
    do begin step; w = w + 1; end while (pin === 1'b1 && w < 300);
    chk("new duty", 3, w);
    wrb(16'hff70, 8'h09);
    chk("pin off", 0, pin);
    test_done;
  end
endmodule // test_timer_h_interval_pwm
